// ===== core/tdma_top.sv
// ten-channel dma controller with wishbone register slave
//
// Overview of operation
// - ten channels, each with own configuration
// - any move inside window, ram or registers
// - start by software trigger or peripheral request
// - count register allows up to 256 transfers
// - addresses confined to 64-kbyte window
// - read then write, bus held from read to write and released after the write
// - fixed, incrementing or ring address per side
// - lower channel number wins, fixed priority
// - count underflow raises grouped interrupt request
// - cascade ring channel 0, 1, 2
// - cascade channel 3 starts channel 4
// - cascade ring channel 5, 6, 7
// - cascade channel 8 starts channel 9
// - channel 0 underflow may start channel 5
// - three cycles per transfer, peak rate
// - grouped status, mask and channel registers
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "tdma_defines.svh"
`default_nettype none

module tdma_top (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [31:0] i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic             o_wb_ack,
	output logic      [31:0] o_wb_dat,
	input  wire logic [9:0]  i_periph_req,
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic             o_mem_size16,
	output logic      [31:0] o_mem_addr,
	output logic      [15:0] o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic [15:0] i_mem_rdata,
	output logic             o_irq
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// lowest index wins
	function automatic logic [3:0] first_set(input logic [9:0] v);
		first_set = 4'h0;
		for (int k = `TDMA_NUM_CH - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = 4'(k);
			end
		end
	endfunction

	// channel whose single completion cascades into channel j
	function automatic logic [4:0] cascade_src(input int j);
		case (j)
			0: cascade_src = {1'b1, 4'd2};
			1: cascade_src = {1'b1, 4'd0};
			2: cascade_src = {1'b1, 4'd1};
			4: cascade_src = {1'b1, 4'd3};
			5: cascade_src = {1'b1, 4'd7};
			6: cascade_src = {1'b1, 4'd5};
			7: cascade_src = {1'b1, 4'd6};
			9: cascade_src = {1'b1, 4'd8};
			default: cascade_src = 5'h00;
		endcase
	endfunction

	function automatic logic [3:0] ch_num(input logic [6:0] idx);
		ch_num = 4'(idx[6:4] - 3'd1) + (idx[3] ? 4'd5 : 4'd0);
	endfunction

	function automatic logic ch_hit(input logic [6:0] idx);
		ch_hit = (idx >= `TDMA_IDX_CH_FIRST) && (idx <= `TDMA_IDX_CH_LAST);
	endfunction

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
		merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
	endfunction

	// next address: fixed, stepped or wrapped inside a ring block
	function automatic logic [15:0] next_addr(input logic [15:0] a,
		input tdma_pkg::tdma_amode_t m, input logic size16);
		logic [15:0] step;
		logic [15:0] sum;
		step = size16 ? 16'h0002 : 16'h0001;
		sum  = a + step;
		case (m)
			tdma_pkg::TDMA_AM_INC:
				next_addr = sum;
			tdma_pkg::TDMA_AM_RING:
				next_addr = (a & ~`TDMA_RING_MASK) | (sum & `TDMA_RING_MASK);
			default:
				next_addr = a;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	tdma_pkg::tdma_ctrl_t  ctrl_q  [`TDMA_NUM_CH];
	logic [7:0]            count_q [`TDMA_NUM_CH];
	logic [15:0]           src_q   [`TDMA_NUM_CH];
	logic [15:0]           dst_q   [`TDMA_NUM_CH];
	logic [9:0]            pend_q;
	logic [9:0]            pend_set;
	logic [9:0]            irq_stat_q;
	logic [9:0]            irq_mask_q;
	logic [9:0]            irq_clr;
	logic [9:0]            ready;
	logic [9:0]            done_vec;
	logic [9:0]            unfl_vec;
	logic [9:0]            sw_trig;
	logic [3:0]            grant;
	logic [3:0]            act_q;
	tdma_pkg::tdma_state_t state_q;
	tdma_pkg::tdma_mem_t   mem_q;
	logic                  done;
	logic                  ack_q;
	logic                  access;
	logic                  wr_en;
	logic [6:0]            idx;
	logic [3:0]            wch;
	logic [31:0]           rdata_d;

	// ------------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------------
	assign idx    = i_wb_adr[8:2];
	assign wch    = ch_num(idx);
	assign access = i_wb_cyc && i_wb_stb && !ack_q;
	assign wr_en  = access && i_wb_we;

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (ch_hit(idx)) begin
			case (idx[2:0])
				`TDMA_FLD_CTRL:  rdata_d = {24'h00_0000, ctrl_q[wch]};
				`TDMA_FLD_COUNT: rdata_d = {24'h00_0000, count_q[wch]};
				`TDMA_FLD_SRC:   rdata_d = {16'h0000, src_q[wch]};
				`TDMA_FLD_DST:   rdata_d = {16'h0000, dst_q[wch]};
				default:         rdata_d = 32'h0000_0000;
			endcase
		end else begin
			case (idx)
				`TDMA_IDX_LO_STAT: rdata_d = {27'h000_0000, irq_stat_q[4:0]};
				`TDMA_IDX_LO_MASK: rdata_d = {27'h000_0000, irq_mask_q[4:0]};
				`TDMA_IDX_HI_STAT: rdata_d = {27'h000_0000, irq_stat_q[9:5]};
				`TDMA_IDX_HI_MASK: rdata_d = {27'h000_0000, irq_mask_q[9:5]};
				default:           rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// one-cycle answer; unmapped reads give zero, writes are dropped
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q    <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			ack_q    <= access;
			o_wb_dat <= access ? rdata_d : 32'h0000_0000;
		end
	end
	assign o_wb_ack = ack_q;

	assign sw_trig = (wr_en && idx == `TDMA_IDX_SW_TRIG && i_wb_sel[0]
		&& i_wb_sel[1]) ? i_wb_dat[9:0] : 10'h000;

	// ------------------------------------------------------------------
	// request sources per channel
	// ------------------------------------------------------------------
	for (genvar j = 0; j < `TDMA_NUM_CH; j++) begin : g_req
		localparam logic [4:0] CSRC = cascade_src(j);
		logic casc;
		logic unfl;
		assign casc = CSRC[4] && done_vec[CSRC[3:0]];
		// channel 0 underflow into channel 5
		assign unfl = (j == 5) && unfl_vec[0];
		always_comb begin
			case (ctrl_q[j].rqsel)
				tdma_pkg::TDMA_RQ_PERIPH:
					pend_set[j] = sw_trig[j] || i_periph_req[j];
				tdma_pkg::TDMA_RQ_CASCADE:
					pend_set[j] = sw_trig[j] || casc;
				tdma_pkg::TDMA_RQ_UNDERFLOW:
					pend_set[j] = sw_trig[j] || unfl;
				default:
					pend_set[j] = sw_trig[j];
			endcase
		end
		assign done_vec[j] = done && (act_q == 4'(j));
		// underflow when count wraps below zero
		assign unfl_vec[j] = done_vec[j] && (count_q[j] == 8'h00);
	end

	// ------------------------------------------------------------------
	// pending requests
	// ------------------------------------------------------------------
	assign ready = pend_q & {ctrl_q[9].enable, ctrl_q[8].enable,
		ctrl_q[7].enable, ctrl_q[6].enable, ctrl_q[5].enable,
		ctrl_q[4].enable, ctrl_q[3].enable, ctrl_q[2].enable,
		ctrl_q[1].enable, ctrl_q[0].enable};
	assign grant = first_set(ready);

	// a new request in the grant cycle survives: set wins over clear
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_q <= 10'h000;
		end else begin
			if (state_q == tdma_pkg::TDMA_ST_IDLE && ready != 10'h000) begin
				pend_q <= (pend_q & ~(10'h001 << grant)) | pend_set;
			end else begin
				pend_q <= pend_q | pend_set;
			end
		end
	end

	// ------------------------------------------------------------------
	// transfer engine
	// ------------------------------------------------------------------
	// one read, one write, then idle
	assign done = (state_q == tdma_pkg::TDMA_ST_WRITE) && i_mem_ack;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= tdma_pkg::TDMA_ST_IDLE;
			act_q   <= 4'h0;
			mem_q   <= '0;
		end else begin
			case (state_q)
				tdma_pkg::TDMA_ST_IDLE: begin
					if (ready != 10'h000) begin
						state_q      <= tdma_pkg::TDMA_ST_READ;
						act_q        <= grant;
						mem_q.req    <= 1'b1;
						mem_q.we     <= 1'b0;
						mem_q.size16 <= ctrl_q[grant].size16;
						mem_q.addr   <= {`TDMA_WIN_BASE, src_q[grant]};
					end
				end
				tdma_pkg::TDMA_ST_READ: begin
					if (i_mem_ack) begin
						state_q     <= tdma_pkg::TDMA_ST_WRITE;
						mem_q.we    <= 1'b1;
						mem_q.wdata <= mem_q.size16 ? i_mem_rdata
							: {8'h00, i_mem_rdata[7:0]};
						mem_q.addr  <= {`TDMA_WIN_BASE, dst_q[act_q]};
					end
				end
				tdma_pkg::TDMA_ST_WRITE: begin
					if (i_mem_ack) begin
						// bus given back for at least one cycle
						state_q   <= tdma_pkg::TDMA_ST_IDLE;
						mem_q.req <= 1'b0;
						mem_q.we  <= 1'b0;
					end
				end
				default: begin
					state_q <= tdma_pkg::TDMA_ST_IDLE;
				end
			endcase
		end
	end

	assign o_mem_req    = mem_q.req;
	assign o_mem_we     = mem_q.we;
	assign o_mem_size16 = mem_q.size16;
	assign o_mem_addr   = mem_q.addr;
	assign o_mem_wdata  = mem_q.wdata;

	// ------------------------------------------------------------------
	// channel registers
	// ------------------------------------------------------------------
	// ten independent channel register sets
	// software writes override the engine's update in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < `TDMA_NUM_CH; c++) begin
				ctrl_q[c]  <= `TDMA_CTRL_RST;
				count_q[c] <= `TDMA_COUNT_RST;
				src_q[c]   <= `TDMA_ADDR_RST;
				dst_q[c]   <= `TDMA_ADDR_RST;
			end
		end else begin
			for (int c = 0; c < `TDMA_NUM_CH; c++) begin
				if (done_vec[c]) begin
					// any source and destination in window
					src_q[c] <= next_addr(src_q[c], ctrl_q[c].smode,
						ctrl_q[c].size16);
					dst_q[c] <= next_addr(dst_q[c], ctrl_q[c].dmode,
						ctrl_q[c].size16);
					// count n gives n plus one transfers
					count_q[c] <= count_q[c] - 8'h01;
					// series over: channel stops itself
					if (unfl_vec[c]) begin
						ctrl_q[c].enable <= 1'b0;
					end
				end
			end
			if (wr_en && ch_hit(idx) && i_wb_sel[0]) begin
				case (idx[2:0])
					`TDMA_FLD_CTRL:  ctrl_q[wch]  <= i_wb_dat[7:0];
					`TDMA_FLD_COUNT: count_q[wch] <= i_wb_dat[7:0];
					default: begin
					end
				endcase
			end
			if (wr_en && ch_hit(idx)) begin
				case (idx[2:0])
					`TDMA_FLD_SRC:
						src_q[wch] <= merge16(src_q[wch], i_wb_dat, i_wb_sel);
					`TDMA_FLD_DST:
						dst_q[wch] <= merge16(dst_q[wch], i_wb_dat, i_wb_sel);
					default: begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// grouped interrupt
	// ------------------------------------------------------------------
	// write-one-to-clear pattern of the two status registers
	always_comb begin
		irq_clr = 10'h000;
		if (wr_en && i_wb_sel[0] && idx == `TDMA_IDX_LO_STAT) begin
			irq_clr[4:0] = i_wb_dat[4:0];
		end
		if (wr_en && i_wb_sel[0] && idx == `TDMA_IDX_HI_STAT) begin
			irq_clr[9:5] = i_wb_dat[4:0];
		end
	end

	// underflow sets status, write one clears
	// hardware set wins over a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_q <= `TDMA_IRQ_RST;
			irq_mask_q <= `TDMA_IRQ_RST;
		end else begin
			if (wr_en && i_wb_sel[0]) begin
				case (idx)
					`TDMA_IDX_LO_MASK: irq_mask_q[4:0] <= i_wb_dat[4:0];
					`TDMA_IDX_HI_MASK: irq_mask_q[9:5] <= i_wb_dat[4:0];
					default: begin
					end
				endcase
			end
			irq_stat_q <= (irq_stat_q & ~irq_clr) | unfl_vec;
		end
	end

	// level while any unmasked status bit set
	assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// ===== core/tdma_defines.svh
// register indexes, field values and timing counts of the dma controller
`ifndef TDMA_DEFINES_SVH
`define TDMA_DEFINES_SVH

// ----------------------------------------------------------------------
// channel count and transfer window
// ----------------------------------------------------------------------
`define TDMA_NUM_CH         10
`define TDMA_CH_PER_GROUP   5
`define TDMA_WIN_BASE       16'h0080
`define TDMA_RING_MASK      16'h001F

// ----------------------------------------------------------------------
// register indexes, byte address on the bus is four times the index
// ----------------------------------------------------------------------
`define TDMA_IDX_LO_STAT    7'h00
`define TDMA_IDX_LO_MASK    7'h01
`define TDMA_IDX_SW_TRIG    7'h02
`define TDMA_IDX_HI_STAT    7'h08
`define TDMA_IDX_HI_MASK    7'h09
`define TDMA_IDX_CH_FIRST   7'h10
`define TDMA_IDX_CH_LAST    7'h5F
`define TDMA_FLD_CTRL       3'h0
`define TDMA_FLD_COUNT      3'h1
`define TDMA_FLD_SRC        3'h2
`define TDMA_FLD_DST        3'h4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TDMA_CTRL_RST       8'h00
`define TDMA_COUNT_RST      8'h00
`define TDMA_ADDR_RST       16'h0000
`define TDMA_IRQ_RST        10'h000

// ----------------------------------------------------------------------
// timing: clock rate and cycles per zero-wait transfer
// ----------------------------------------------------------------------
`define TDMA_CLK_MHZ        200
`define TDMA_XFER_CYCLES    3

`endif

// ===== core/tdma_pkg.sv
// types shared by the dma controller
`default_nettype none

package tdma_pkg;

	typedef enum logic [1:0] {
		TDMA_AM_FIXED,
		TDMA_AM_INC,
		TDMA_AM_RING,
		TDMA_AM_SPARE
	} tdma_amode_t;

	typedef enum logic [1:0] {
		TDMA_RQ_SOFT,
		TDMA_RQ_PERIPH,
		TDMA_RQ_CASCADE,
		TDMA_RQ_UNDERFLOW
	} tdma_rqsel_t;

	// channel control register layout, bit 0 is enable
	typedef struct packed {
		tdma_rqsel_t rqsel;
		tdma_amode_t dmode;
		tdma_amode_t smode;
		logic        size16;
		logic        enable;
	} tdma_ctrl_t;

	typedef enum {
		TDMA_ST_IDLE,
		TDMA_ST_READ,
		TDMA_ST_WRITE
	} tdma_state_t;

	// internal bus request of the transfer engine
	typedef struct packed {
		logic        req;
		logic        we;
		logic        size16;
		logic [31:0] addr;
		logic [15:0] wdata;
	} tdma_mem_t;

endpackage

`default_nettype wire

// ===== sim/tdma_sva.sv
// port checker of the dma controller
`default_nettype none

module tdma_sva (
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic        o_mem_size16,
	input wire logic [31:0] o_mem_addr,
	input wire logic [15:0] o_mem_wdata,
	input wire logic        i_mem_ack
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_delay: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
		|=> o_wb_ack) else $error("ack not one cycle after request");
	a_dat_idle: assert property (!o_wb_ack
		|-> o_wb_dat == 32'h0000_0000) else $error("read data off ack");
	a_addr_window: assert property (o_mem_req
		|-> o_mem_addr[31:16] == 16'h0080) else $error("address off window");
	a_req_hold: assert property (o_mem_req && !i_mem_ack
		|=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
		else $error("request changed before answer");
	a_read_write: assert property (o_mem_req && !o_mem_we && i_mem_ack
		|=> o_mem_req && o_mem_we) else $error("no write after read");
	a_bus_release: assert property (o_mem_req && o_mem_we && i_mem_ack
		|=> !o_mem_req) else $error("bus kept after write");
	a_read_first: assert property ($rose(o_mem_req) |-> !o_mem_we)
		else $error("transfer began with write");
	a_byte_lane: assert property (o_mem_req && o_mem_we && !o_mem_size16
		|-> o_mem_wdata[15:8] == 8'h00) else $error("byte upper lane set");

	c_write: cover property (o_mem_req && o_mem_we && i_mem_ack);
	c_wait: cover property (o_mem_req && !i_mem_ack);
	c_reg: cover property (i_wb_cyc && o_wb_ack);
endmodule

`default_nettype wire

// ===== sim/tdma_mem_model.sv
// ram and register space behind the dma memory port
`default_nettype none

module tdma_mem_model (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic        i_size16,
	input  wire logic [31:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [1:0]  i_lat,
	output logic             o_ack,
	output logic      [15:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:65535];
	logic [1:0]  wait_q;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] a;

	assign a = i_addr[15:0];
	// zero wait answers in the request cycle
	assign o_ack = i_req && (wait_q >= i_lat);
	// released data lines show the inverse, not a held value
	assign o_rdata = (i_req && !i_we) ?
		{i_size16 ? mem[a + 16'h0001] : 8'h00, mem[a]} : ~last_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_q <= 2'h0;
		end else begin
			wait_q <= (i_req && !o_ack) ? wait_q + 2'h1 : 2'h0;
		end
	end

	always @(posedge i_clock) begin
		if (o_ack) begin
			last_q <= o_rdata;
		end
		if (i_req && i_we && o_ack) begin
			mem[a] <= i_wdata[7:0];
			if (i_size16) begin
				mem[a + 16'h0001] <= i_wdata[15:8];
			end
		end
	end
endmodule

`default_nettype wire

// ===== sim/test_tdma_top.sv
// self-checking testbench of the dma controller
`default_nettype none

module test_tdma_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_wb_cyc = 1'b0;
	logic        i_wb_stb = 1'b0;
	logic        i_wb_we = 1'b0;
	logic [31:0] i_wb_adr = '0;
	logic [31:0] i_wb_dat = '0;
	logic [3:0]  i_wb_sel = '0;
	logic [9:0]  i_periph_req = '0;
	logic [1:0]  lat = '0;
	logic        o_wb_ack, o_mem_req, o_mem_we, o_mem_size16, o_irq;
	logic        i_mem_ack;
	logic [31:0] o_wb_dat, o_mem_addr, rd, e;
	logic [15:0] o_mem_wdata, i_mem_rdata;
	logic [15:0] rq [$];
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc_n = 0;
	int          rt [$];

	tdma_top dut (.i_clock, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
		.i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .o_wb_dat,
		.i_periph_req, .o_mem_req, .o_mem_we, .o_mem_size16, .o_mem_addr,
		.o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_irq);
	tdma_mem_model u_mem (.i_clock, .i_rst_n, .i_req(o_mem_req),
		.i_we(o_mem_we), .i_size16(o_mem_size16), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .i_lat(lat), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));

	always #2.5 i_clock = ~i_clock;
	// read answers with their cycle number, for order and rate checks
	always @(posedge i_clock) begin
		cyc_n++;
		if (o_mem_req && !o_mem_we && i_mem_ack) begin
			rq.push_back(o_mem_addr[15:0]);
			rt.push_back(cyc_n);
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [6:0] idx,
		input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		@(posedge i_clock);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= {23'h00_0000, idx, 2'h0};
		i_wb_dat <= d;
		i_wb_sel <= s;
		do @(posedge i_clock); while (o_wb_ack !== 1'b1 && ++k < 50);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
		chk("ack", {31'h0, o_wb_ack}, 32'h1);
	endtask

	// wait until the engine stays idle for six cycles
	task automatic settle();
		int q, k;
		q = 0;
		for (k = 0; k < 400 && q < 6; k++) begin
			@(posedge i_clock);
			q = o_mem_req ? 0 : q + 1;
		end
		chk("idle", {31'h0, q == 6}, 32'h1);
	endtask

	task automatic trig(input logic [9:0] m);
		wb(1'b1, 7'h02, {22'h00_0000, m}, 4'h3);
		settle();
	endtask

	function automatic logic [7:0] cw(input logic [1:0] q, d, s,
		input logic sz);
		return {q, d, s, sz, 1'b1};
	endfunction

	task automatic cfg(input int ch, input logic [7:0] ctl, cnt,
		input logic [15:0] sa, da);
		logic [6:0] b;
		b = 7'(16 + 16 * (ch % 5) + 8 * (ch / 5));
		wb(1'b1, b + 7'h02, {16'h0000, sa}, 4'h3);
		wb(1'b1, b + 7'h04, {16'h0000, da}, 4'h3);
		wb(1'b1, b + 7'h01, {24'h00_0000, cnt}, 4'h1);
		wb(1'b1, b, {24'h00_0000, ctl}, 4'h1);
	endtask

	task automatic t_regs();
		wb(1'b0, 7'h10, 32'h0, 4'hF);
		chk("ctrl reset", rd, 32'h0);
		wb(1'b1, 7'h7F, 32'hFFFF_FFFF, 4'hF);
		wb(1'b0, 7'h7F, 32'h0, 4'hF);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, 7'h09, 32'h0000_0000, 4'h1);
		wb(1'b1, 7'h01, 32'h0000_0008, 4'h1);
		wb(1'b0, 7'h01, 32'h0, 4'h1);
		chk("mask", rd, 32'h0000_0008);
	endtask

	task automatic t_copy();
		u_mem.mem[16'h0100] = 8'h5A;
		u_mem.mem[16'h0101] = 8'hC3;
		u_mem.mem[16'h013E] = 8'h11;
		u_mem.mem[16'h013F] = 8'h22;
		u_mem.mem[16'h0120] = 8'h33;
		u_mem.mem[16'h0160] = 8'h34;
		u_mem.mem[16'h0161] = 8'h12;
		cfg(3, cw(tdma_pkg::TDMA_RQ_SOFT, tdma_pkg::TDMA_AM_INC,
			tdma_pkg::TDMA_AM_INC, 1'b0), 8'h01, 16'h0100, 16'h0110);
		trig(10'h008);
		chk("irq early", {31'h0, o_irq}, 32'h0);
		trig(10'h008);
		chk("irq", {31'h0, o_irq}, 32'h1);
		e = {16'h0000, u_mem.mem[16'h0111], u_mem.mem[16'h0110]};
		chk("copy", e, 32'h0000_C35A);
		wb(1'b0, 7'h41, 32'h0, 4'h1);
		chk("count wrap", rd, 32'h0000_00FF);
		wb(1'b0, 7'h00, 32'h0, 4'h1);
		chk("low status", rd, 32'h0000_0008);
		wb(1'b1, 7'h00, 32'h0000_0008, 4'h1);
		chk("irq clear", {31'h0, o_irq}, 32'h0);
		cfg(6, cw(tdma_pkg::TDMA_RQ_SOFT, tdma_pkg::TDMA_AM_INC,
			tdma_pkg::TDMA_AM_RING, 1'b0), 8'h02, 16'h013E, 16'h0150);
		repeat (3) trig(10'h040);
		e = {8'h00, u_mem.mem[16'h0152], u_mem.mem[16'h0151],
			u_mem.mem[16'h0150]};
		chk("ring", e, 32'h0033_2211);
		wb(1'b0, 7'h08, 32'h0, 4'h1);
		chk("high status", rd, 32'h0000_0002);
		chk("irq masked", {31'h0, o_irq}, 32'h0);
		lat <= 2'h2;
		cfg(9, cw(tdma_pkg::TDMA_RQ_PERIPH, tdma_pkg::TDMA_AM_INC,
			tdma_pkg::TDMA_AM_FIXED, 1'b1), 8'h01, 16'h0160, 16'h0170);
		repeat (2) begin
			@(posedge i_clock);
			i_periph_req <= 10'h200;
			@(posedge i_clock);
			i_periph_req <= 10'h000;
			settle();
		end
		e = {u_mem.mem[16'h0173], u_mem.mem[16'h0172],
			u_mem.mem[16'h0171], u_mem.mem[16'h0170]};
		chk("wide", e, 32'h1234_1234);
		lat <= 2'h0;
	endtask

	task automatic t_prio();
		rq.delete();
		rt.delete();
		cfg(7, cw(tdma_pkg::TDMA_RQ_SOFT, tdma_pkg::TDMA_AM_INC,
			tdma_pkg::TDMA_AM_INC, 1'b0), 8'h00, 16'h0187, 16'h0197);
		cfg(2, cw(tdma_pkg::TDMA_RQ_SOFT, tdma_pkg::TDMA_AM_INC,
			tdma_pkg::TDMA_AM_INC, 1'b0), 8'h00, 16'h0182, 16'h0192);
		trig(10'h084);
		chk("first", {16'h0000, rq[0]}, 32'h0000_0182);
		chk("second", {16'h0000, rq[1]}, 32'h0000_0187);
		// zero wait: idle, read, write, so reads come three cycles apart
		chk("rate", 32'(rt[1] - rt[0]), 32'h0000_0003);
	endtask

	task automatic t_chain();
		int s [5] = '{3, 8, 2, 7, 0};
		int d [5] = '{4, 9, 0, 5, 5};
		for (int i = 0; i < 5; i++) begin
			u_mem.mem[16'h01C0 + i] = 8'hC0 + 8'(i);
			cfg(d[i], cw(i == 4 ? tdma_pkg::TDMA_RQ_UNDERFLOW :
				tdma_pkg::TDMA_RQ_CASCADE, tdma_pkg::TDMA_AM_INC,
				tdma_pkg::TDMA_AM_INC, 1'b0), 8'h00, 16'h01C0 + 16'(i),
				16'h01D0 + 16'(i));
			cfg(s[i], cw(tdma_pkg::TDMA_RQ_SOFT, tdma_pkg::TDMA_AM_FIXED,
				tdma_pkg::TDMA_AM_FIXED, 1'b0), 8'h00, 16'h01B0, 16'h01B8);
			trig(10'(1 << s[i]));
			e = {24'h00_0000, 8'hC0 + 8'(i)};
			rd = {24'h00_0000, u_mem.mem[16'h01D0 + i]};
			chk("chain", rd, e);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_regs();
		t_copy();
		t_prio();
		t_chain();
		wrap_up();
	end

	// whole run needs a few hundred cycles
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
endmodule

bind tdma_top tdma_sva u_sva (.i_clock, .i_rst_n, .i_wb_cyc, .i_wb_stb,
	.o_wb_ack, .o_wb_dat, .o_mem_req, .o_mem_we, .o_mem_size16,
	.o_mem_addr, .o_mem_wdata, .i_mem_ack);

`default_nettype wire
